// ===== verilog/sfr_defines.vh
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
// instruction codes
`define SFR_CMD_READ 8'h03
`define SFR_CMD_FAST 8'h0B
`define SFR_CMD_DUAL_OUT 8'h3B
`define SFR_CMD_QUAD_OUT 8'h6B
`define SFR_CMD_DUAL_IO 8'hBB
`define SFR_CMD_RESUME 8'h7A
`define SFR_CMD_CRM_RESET 8'hFF
// serial framing
`define SFR_CMD_BITS 8
`define SFR_ADDR_BITS 24
`define SFR_DUMMY_LEGACY 5'h08
`define SFR_DIO_LAT_LEGACY 5'h04
`define SFR_DIO_MODE_CLKS 5'h04
// continue_select_field position and value
`define SFR_SEL_HI 5
`define SFR_SEL_LO 4
`define SFR_CONT_SEL 2'h2
// idle pin and data values
`define SFR_OE_OFF 4'hF
`define SFR_EMPTY_BYTE 8'hFF
// resume timing
`define SFR_CLK_MHZ 50
`define SFR_T_BUSY_NS 200
`define SFR_BUSY_CYC ((`SFR_T_BUSY_NS * `SFR_CLK_MHZ) / 1000)
`endif

// ===== verilog/sfr_read_resume.v
// Operation
// - resume acts only with suspend flag set and busy flag clear.
// - accepted resume clears suspend at once, raises busy within 200 ns.
// - resume ignored when suspend flag is 0 or busy flag is 1.
// - read 03h plus 24-bit address sampled on rising clock edges.
// - addressed byte driven msb first, changing on falling edges.
// - address increments per byte; read ends when chip select rises.
// - read ignored while busy; running cycle untouched.
// - fast read 0Bh has eight dummy clocks; input ignored then.
// - variable latency takes dummy count from latency control field.
// - dual output 3Bh sends two bits per clock after dummies.
// - quad output 6Bh only with quad enable; four bits per clock.
// - dual io BBh takes address and returns data on two lines.
// - select field 10 makes next transaction start at the address.
// - select field not 10 leaves continuous read mode.
// - lower mode nibble is don't-care; host may release lines.
// - dual io legacy four mode clocks; variable uses latency field.
// - continuous-read reset clears stored mode bits.
// - all-ones sequence leaves continuous read mode.
`timescale 1ns/1ps
`include "sfr_defines.vh"

////////////////////////////////////////////////////////////////////////
module sfr_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	input wire flush,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	assign in_ready = (count_reg != DEPTH);
	assign out_valid = (count_reg != 0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	always @(posedge core_clk)
	begin
		if (!rst_n || flush)
		begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // sfr_fifo

////////////////////////////////////////////////////////////////////////
module sfr_read_resume #(
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// serial pins
	input wire cs_n_pin,
	input wire sclk_pin,
	input wire [3:0] io_in,
	output reg [3:0] io_out,
	output reg [3:0] io_oe_n,
	// status flags
	input wire busy_flag,
	input wire suspend_flag,
	input wire quad_enable_bit,
	input wire var_lat_en,
	input wire [3:0] lat_ctrl,
	// resume controls
	output reg suspend_clr,
	output reg busy_set,
	// memory array
	output reg [23:0] mem_addr,
	output reg mem_req,
	input wire [7:0] mem_rdata,
	input wire mem_rvalid,
	output wire mem_rready,
	// mode status
	output wire cont_mode
);
	localparam [2:0] ST_CMD = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_LAT = 3'h2;
	localparam [2:0] ST_DATA = 3'h3;
	localparam [2:0] ST_IGN = 3'h4;
	localparam integer CMD_LAST_I = `SFR_CMD_BITS - 1;
	localparam integer ADDR_LAST1_I = `SFR_ADDR_BITS - 1;
	localparam integer ADDR_LAST2_I = `SFR_ADDR_BITS / 2 - 1;
	localparam integer BUSY_CYC_I = `SFR_BUSY_CYC;
	localparam [4:0] CMD_LAST = CMD_LAST_I[4:0];
	localparam [4:0] ADDR_LAST1 = ADDR_LAST1_I[4:0];
	localparam [4:0] ADDR_LAST2 = ADDR_LAST2_I[4:0];
	localparam [3:0] BUSY_CYC = BUSY_CYC_I[3:0];

	// latency clocks after the address for a read instruction
	function [4:0] fn_lat;
		input [7:0] cmd;
		input var_en;
		input [3:0] lat;
		begin
			if (cmd == `SFR_CMD_READ)
				fn_lat = 5'h00;
			else if (var_en)
				fn_lat = {1'b0, lat};
			else if (cmd == `SFR_CMD_DUAL_IO)
				fn_lat = `SFR_DIO_LAT_LEGACY;
			else
				fn_lat = `SFR_DUMMY_LEGACY;
		end
	endfunction

	// bits per clock on the output side
	function [3:0] fn_out_w;
		input [7:0] cmd;
		begin
			if (cmd == `SFR_CMD_QUAD_OUT)
				fn_out_w = 4'h4;
			else if (cmd == `SFR_CMD_DUAL_OUT || cmd == `SFR_CMD_DUAL_IO)
				fn_out_w = 4'h2;
			else
				fn_out_w = 4'h1;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// pin synchronisers, third stage only for edge finding
	reg [2:0] cs_sync_reg;
	reg [2:0] sclk_sync_reg;
	reg [3:0] io_s1_reg;
	reg [3:0] io_s2_reg;
	wire cs_s;
	wire cs_rise;
	wire cs_fall;
	wire sclk_rise;
	wire sclk_fall;
	wire io0;
	wire io1;

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cs_sync_reg <= 3'h7;
			sclk_sync_reg <= 3'h0;
			io_s1_reg <= 4'h0;
			io_s2_reg <= 4'h0;
		end
		else
		begin
			cs_sync_reg <= {cs_sync_reg[1:0], cs_n_pin};
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_pin};
			io_s1_reg <= io_in;
			io_s2_reg <= io_s1_reg;
		end
	end

	assign cs_s = cs_sync_reg[1];
	assign cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
	assign cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	assign io0 = io_s2_reg[0];
	assign io1 = io_s2_reg[1];

	////////////////////////////////////////////////////////////////////
	// serial decoder
	reg [2:0] state_reg;
	reg [4:0] cnt_reg;
	reg [4:0] lat_reg;
	reg [7:0] cmd_reg;
	reg [7:0] cmd_sr_reg;
	reg [23:0] addr_sr_reg;
	reg [7:0] mode_reg;
	reg mode_done_reg;
	reg in_w2_reg;
	reg cont_reg;
	reg cont_txn_reg;
	reg all_ones_reg;
	reg res_cand_reg;
	reg fetch_on_reg;
	wire fetch_start;
	wire [7:0] cmd_next;
	wire [23:0] addr_next;
	wire addr_last;
	wire [4:0] lat_next;
	wire read_cmd;
	wire read_ok;

	assign cmd_next = {cmd_sr_reg[6:0], io0};
	assign addr_next = in_w2_reg ? {addr_sr_reg[21:0], io1, io0}
		: {addr_sr_reg[22:0], io0};
	assign addr_last = (cnt_reg == (in_w2_reg ? ADDR_LAST2 : ADDR_LAST1));
	assign lat_next = fn_lat(cmd_reg, var_lat_en, lat_ctrl);
	assign read_cmd = (cmd_next == `SFR_CMD_READ)
		|| (cmd_next == `SFR_CMD_FAST)
		|| (cmd_next == `SFR_CMD_DUAL_OUT)
		|| (cmd_next == `SFR_CMD_QUAD_OUT)
		|| (cmd_next == `SFR_CMD_DUAL_IO);
	// quad output needs the quad enable bit
	assign read_ok = read_cmd && !busy_flag &&
		(cmd_next != `SFR_CMD_QUAD_OUT || quad_enable_bit);
	assign cont_mode = cont_reg;
	// fetch starts on the last address bit itself: any later start
	// leaves the first byte missing at the first data edge
	assign fetch_start = !cs_s && !cs_fall && sclk_rise
		&& state_reg == ST_ADDR && addr_last;

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_CMD;
			cnt_reg <= 5'h00;
			lat_reg <= 5'h00;
			cmd_reg <= 8'h00;
			cmd_sr_reg <= 8'h00;
			addr_sr_reg <= 24'h000000;
			mode_reg <= 8'h00;
			mode_done_reg <= 1'b0;
			in_w2_reg <= 1'b0;
			cont_reg <= 1'b0;
			cont_txn_reg <= 1'b0;
			all_ones_reg <= 1'b0;
			res_cand_reg <= 1'b0;
			fetch_on_reg <= 1'b0;
		end
		else
		begin
			if (cs_rise)
			begin
				state_reg <= ST_CMD;
				fetch_on_reg <= 1'b0;
				res_cand_reg <= 1'b0;
				if (cmd_reg == `SFR_CMD_DUAL_IO && mode_done_reg)
					cont_reg <= (mode_reg[`SFR_SEL_HI:`SFR_SEL_LO]
						== `SFR_CONT_SEL);
				else if (cont_txn_reg && all_ones_reg)
					cont_reg <= 1'b0;
			end
			else if (cs_fall)
			begin
				// a stored select field skips the instruction byte
				cnt_reg <= 5'h00;
				mode_done_reg <= 1'b0;
				cont_txn_reg <= cont_reg;
				all_ones_reg <= 1'b1;
				in_w2_reg <= cont_reg;
				if (cont_reg)
				begin
					cmd_reg <= `SFR_CMD_DUAL_IO;
					state_reg <= busy_flag ? ST_IGN : ST_ADDR;
				end
				else
					state_reg <= ST_CMD;
			end
			else if (!cs_s && sclk_rise)
			begin
				if (cont_txn_reg && (state_reg == ST_ADDR
					|| state_reg == ST_LAT) && !(io0 && io1))
					all_ones_reg <= 1'b0;
				case (state_reg)
				ST_CMD:
				begin
					cmd_sr_reg <= cmd_next;
					cnt_reg <= cnt_reg + 5'h01;
					if (cnt_reg == CMD_LAST)
					begin
						cmd_reg <= cmd_next;
						cnt_reg <= 5'h00;
						in_w2_reg <= (cmd_next == `SFR_CMD_DUAL_IO);
						state_reg <= read_ok ? ST_ADDR : ST_IGN;
						res_cand_reg <= (cmd_next == `SFR_CMD_RESUME);
						if (cmd_next == `SFR_CMD_CRM_RESET)
							cont_reg <= 1'b0;
					end
				end
				ST_ADDR:
				begin
					addr_sr_reg <= addr_next;
					cnt_reg <= cnt_reg + 5'h01;
					if (addr_last)
					begin
						cnt_reg <= 5'h00;
						lat_reg <= lat_next;
						fetch_on_reg <= 1'b1;
						state_reg <= (lat_next == 5'h00) ? ST_DATA : ST_LAT;
					end
				end
				ST_LAT:
				begin
					// dummy clocks ignore the inputs
					cnt_reg <= cnt_reg + 5'h01;
					if (cmd_reg == `SFR_CMD_DUAL_IO
						&& cnt_reg < `SFR_DIO_MODE_CLKS)
					begin
						mode_reg <= {mode_reg[5:0], io1, io0};
						if (cnt_reg == `SFR_DIO_MODE_CLKS - 5'h01)
							mode_done_reg <= 1'b1;
					end
					if (cnt_reg == lat_reg - 5'h01)
						state_reg <= ST_DATA;
				end
				ST_DATA:
					state_reg <= ST_DATA;
				ST_IGN:
					state_reg <= ST_IGN;
				default:
					state_reg <= ST_CMD;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// resume: acted on at deselect, busy raised after a short delay
	reg [3:0] busy_cnt_reg;

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			suspend_clr <= 1'b0;
			busy_set <= 1'b0;
			busy_cnt_reg <= 4'h0;
		end
		else
		begin
			suspend_clr <= 1'b0;
			busy_set <= 1'b0;
			if (cs_rise && res_cand_reg && suspend_flag && !busy_flag)
			begin
				suspend_clr <= 1'b1;
				busy_cnt_reg <= BUSY_CYC;
			end
			else if (busy_cnt_reg != 4'h0)
			begin
				busy_cnt_reg <= busy_cnt_reg - 4'h1;
				if (busy_cnt_reg == 4'h1)
					busy_set <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// prefetch: one outstanding request, memory stalled by a full fifo
	reg pend_reg;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire fifo_pop;
	wire fifo_flush;

	assign mem_rready = fifo_in_ready;
	assign fifo_flush = cs_rise | fetch_start;

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			mem_addr <= 24'h000000;
			mem_req <= 1'b0;
			pend_reg <= 1'b0;
		end
		else
		begin
			mem_req <= 1'b0;
			if (fetch_start)
			begin
				mem_addr <= addr_next;
				mem_req <= 1'b1;
				pend_reg <= 1'b1;
			end
			else if (!fetch_on_reg)
				pend_reg <= 1'b0;
			else if (pend_reg)
			begin
				if (mem_rvalid && fifo_in_ready)
				begin
					pend_reg <= 1'b0;
					mem_addr <= mem_addr + 24'h000001;
				end
			end
			else if (fifo_in_ready)
			begin
				mem_req <= 1'b1;
				pend_reg <= 1'b1;
			end
		end
	end

	sfr_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.flush(fifo_flush),
		.in_valid(mem_rvalid & pend_reg & fetch_on_reg),
		.in_ready(fifo_in_ready),
		.in_data(mem_rdata),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////
	// output shifter on falling edges
	reg [7:0] out_sr_reg;
	reg [3:0] bits_left_reg;
	reg [3:0] out_w_reg;
	reg [7:0] cur_byte;
	wire out_step;

	assign out_step = !cs_s && sclk_fall && state_reg == ST_DATA;
	assign fifo_pop = out_step && bits_left_reg == 4'h0;

	always @*
	begin
		cur_byte = out_sr_reg;
		if (bits_left_reg == 4'h0)
			cur_byte = fifo_out_valid ? fifo_out_data : `SFR_EMPTY_BYTE;
	end

	always @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			io_out <= 4'h0;
			io_oe_n <= `SFR_OE_OFF;
			out_sr_reg <= 8'h00;
			bits_left_reg <= 4'h0;
			out_w_reg <= 4'h1;
		end
		else if (cs_s || state_reg != ST_DATA)
		begin
			io_oe_n <= `SFR_OE_OFF;
			bits_left_reg <= 4'h0;
			out_w_reg <= fn_out_w(cmd_reg);
		end
		else if (out_step)
		begin
			out_sr_reg <= cur_byte << out_w_reg;
			bits_left_reg <= ((bits_left_reg == 4'h0) ? 4'h8
				: bits_left_reg) - out_w_reg;
			case (out_w_reg)
			4'h4:
			begin
				io_out <= cur_byte[7:4];
				io_oe_n <= 4'h0;
			end
			4'h2:
			begin
				io_out <= {2'h0, cur_byte[7:6]};
				io_oe_n <= 4'hC;
			end
			default:
			begin
				io_out <= {2'h0, cur_byte[7], 1'b0};
				io_oe_n <= 4'hD;
			end
			endcase
		end
	end
endmodule // sfr_read_resume

// ===== bench/sfr_read_resume_props.sv
`timescale 1ns/1ps
module sfr_read_resume_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// serial pins
	input wire logic cs_n_pin,
	input wire logic [3:0] io_oe_n,
	// status flags
	input wire logic busy_flag,
	input wire logic suspend_flag,
	input wire logic quad_enable_bit,
	// resume and fetch
	input wire logic suspend_clr,
	input wire logic busy_set,
	input wire logic [23:0] mem_addr,
	input wire logic mem_req,
	input wire logic mem_rvalid,
	input wire logic mem_rready,
	input wire logic cont_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// busy comes a fixed 200 ns after the suspend flag clears
	sequence resume_s;
		suspend_clr ##10 busy_set;
	endsequence
	reset_quiet_a: assert property (
		$rose(rst_n) |-> io_oe_n == 4'hF && !mem_req && !cont_mode)
		else $error("outputs active right after reset");
	idle_release_a: assert property (
		cs_n_pin [*4] |-> io_oe_n == 4'hF)
		else $error("data line driven while deselected");
	frame_quiet_a: assert property (
		$fell(cs_n_pin) |=> (io_oe_n == 4'hF) [*8])
		else $error("data line driven at frame start");
	resume_seq_a: assert property (suspend_clr |-> resume_s)
		else $error("busy not raised 10 cycles after clear");
	busy_cause_a: assert property (
		busy_set |-> $past(suspend_clr, 10))
		else $error("busy raised without resume");
	resume_cond_a: assert property (
		suspend_clr |-> suspend_flag && !busy_flag)
		else $error("resume taken with wrong flags");
	req_single_a: assert property (mem_req |=> !mem_req)
		else $error("back to back fetch requests");
	addr_step_a: assert property (
		mem_rvalid && mem_rready |=> mem_addr == $past(mem_addr) + 24'h1)
		else $error("fetch address did not step");
	quad_off_a: assert property (
		!quad_enable_bit |-> io_oe_n[3:2] == 2'h3)
		else $error("quad lines driven without enable");
endmodule // sfr_read_resume_props

bind sfr_read_resume sfr_read_resume_props u_props (.core_clk, .rst_n,
	.cs_n_pin, .io_oe_n, .busy_flag, .suspend_flag, .quad_enable_bit,
	.suspend_clr, .busy_set, .mem_addr, .mem_req, .mem_rvalid,
	.mem_rready, .cont_mode);

// ===== bench/sfr_mem_model.sv
`timescale 1ns/1ps
module sfr_mem_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// fetch port
	input wire logic mem_req,
	input wire logic [23:0] mem_addr,
	input wire logic mem_rready,
	output logic mem_rvalid,
	output logic [7:0] mem_rdata
);
	logic v_reg;
	logic [7:0] d_reg;
	// stale byte is inverted so it never passes for fresh data
	assign mem_rdata = v_reg ? d_reg : ~d_reg;
	assign mem_rvalid = v_reg;
	always @(posedge core_clk)
	begin
		if (!rst_n)
			v_reg <= 1'b0;
		else if (mem_req)
		begin
			v_reg <= 1'b1;
			d_reg <= mem_addr[7:0] ^ 8'h5A;
		end
		else if (mem_rready)
			v_reg <= 1'b0;
	end
endmodule // sfr_mem_model

// ===== bench/sfr_read_resume_tb.sv
`timescale 1ns/1ps
module sfr_read_resume_tb;
	logic core_clk, rst_n, cs_n_pin, sclk_pin, busy_flag, suspend_flag;
	logic quad_enable_bit, var_lat_en, suspend_clr, busy_set, mem_req;
	logic mem_rvalid, mem_rready, cont_mode;
	logic [3:0] io_in, io_out, io_oe_n, lat_ctrl, hv, cap, oe;
	logic [23:0] mem_addr;
	logic [7:0] mem_rdata, b;
	int fails, compares;
	// pin level: device wins where it drives, host value elsewhere
	assign io_in = (~io_oe_n & io_out) | (io_oe_n & hv);
	sfr_read_resume u_dut (.core_clk, .rst_n, .cs_n_pin, .sclk_pin, .io_in,
		.io_out, .io_oe_n, .busy_flag, .suspend_flag, .quad_enable_bit,
		.var_lat_en, .lat_ctrl, .suspend_clr, .busy_set, .mem_addr,
		.mem_req, .mem_rdata, .mem_rvalid, .mem_rready, .cont_mode);
	sfr_mem_model u_mem (.core_clk, .rst_n, .mem_req, .mem_addr,
		.mem_rready, .mem_rvalid, .mem_rdata);
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	function automatic logic [7:0] ev(input logic [23:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	////////////////////////////////////////////////////////////////////////
	// one 160 ns serial clock; outputs captured just before the rise
	task tk(input logic [3:0] v);
		hv = v;
		sclk_pin = 1'b0;
		repeat (4) @(negedge core_clk);
		cap = io_out;
		oe = io_oe_n;
		sclk_pin = 1'b1;
		repeat (4) @(negedge core_clk);
	endtask
	task sb(input logic [31:0] w, input int n);
		for (int k = n - 1; k >= 0; k--) tk({3'h0, w[k]});
	endtask
	task s2(input logic [31:0] w, input int n);
		for (int k = n - 1; k > 0; k -= 2) tk({2'h0, w[k], w[k-1]});
	endtask
	task rb(input int ln, input logic [3:0] eo);
		for (int k = 0; k < 8 / ln; k++)
		begin
			tk(k[3:0]);
			b = ln == 1 ? {b[6:0], cap[1]} :
				ln == 2 ? {b[5:0], cap[1:0]} : {b[3:0], cap};
			chk(oe, eo);
		end
	endtask
	task bg;
		cs_n_pin = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask
	task fin;
		cs_n_pin = 1'b1;
		repeat (6) @(negedge core_clk);
		chk(io_oe_n, 4'hF);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_read;
		bg;
		sb(8'h03, 8);
		sb(24'h0012FF, 24);
		rb(1, 4'hD);
		chk(b, ev(24'h0012FF));
		rb(1, 4'hD);
		chk(b, ev(24'h001300));
		fin;
		$display("read test done");
	endtask
	task t_fast(input logic [7:0] c, input int ln, input logic [3:0] eo,
		input int nd);
		bg;
		sb(c, 8);
		sb(24'h000040, 24);
		sb(32'hFFFFFFFF, nd);
		rb(ln, eo);
		chk(b, ev(24'h000040));
		fin;
		$display("fast read test done");
	endtask
	task t_refuse;
		busy_flag = 1'b1;
		bg;
		sb(8'h03, 8);
		sb(24'h0, 24);
		rb(1, 4'hF);
		fin;
		busy_flag = 1'b0;
		quad_enable_bit = 1'b0;
		bg;
		sb(8'h6B, 8);
		sb(24'h0, 32);
		rb(4, 4'hF);
		fin;
		$display("refusal test done");
	endtask
	task rs(input logic su, input logic bz, input logic ex);
		int n, sn;
		n = 0;
		sn = 0;
		suspend_flag = su;
		busy_flag = bz;
		bg;
		sb(8'h7A, 8);
		cs_n_pin = 1'b1;
		for (int k = 1; k < 30; k++)
		begin
			@(negedge core_clk);
			if (suspend_clr === 1'b1) sn = k;
			if (busy_set === 1'b1) n = k;
		end
		chk(sn != 0, ex);
		if (ex) chk(n - sn, 10);
		suspend_flag = 1'b0;
		busy_flag = 1'b0;
		$display("resume test done");
	endtask
	task t_dio;
		bg;
		sb(8'hBB, 8);
		s2(24'h000080, 24);
		s2(8'h2F, 8);
		rb(2, 4'hC);
		chk(b, ev(24'h000080));
		fin;
		chk(cont_mode, 1'b1);
		bg;
		s2(24'h0000C0, 24);
		s2(8'h00, 8);
		rb(2, 4'hC);
		chk(b, ev(24'h0000C0));
		fin;
		chk(cont_mode, 1'b0);
		bg;
		sb(8'hBB, 8);
		s2(24'h000080, 24);
		s2(8'hE0, 8);
		fin;
		chk(cont_mode, 1'b1);
		// host restarted while the device is in continuous mode; mode is left
		bg;
		repeat (16) tk(4'hF);
		fin;
		chk(cont_mode, 1'b0);
		$display("dual io test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_n, busy_flag, suspend_flag, quad_enable_bit, var_lat_en} = 5'h0;
		{cs_n_pin, sclk_pin, hv, lat_ctrl} = 10'h300;
		fails = 0;
		compares = 0;
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		t_read;
		t_fast(8'h0B, 1, 4'hD, 8);
		t_fast(8'h3B, 2, 4'hC, 8);
		quad_enable_bit = 1'b1;
		t_fast(8'h6B, 4, 4'h0, 8);
		var_lat_en = 1'b1;
		lat_ctrl = 4'h3;
		t_fast(8'h0B, 1, 4'hD, 3);
		var_lat_en = 1'b0;
		t_refuse;
		rs(1'b1, 1'b0, 1'b1);
		rs(1'b0, 1'b0, 1'b0);
		rs(1'b1, 1'b1, 1'b0);
		t_dio;
		t_read;
		give_verdict;
	end
	// whole run is near 80 us; this is well beyond it
	initial
	begin
		#1000000;
		fails++;
		$display("watchdog expired");
		give_verdict;
	end
endmodule // sfr_read_resume_tb
